// file: rtl/pbpm_pkg.sv
package pbpm_pkg;
  // Configuration dword offsets (byte addresses, low two bits ignored).
  localparam logic [7:0] PBPM_BCTRL_DW_OFS = 8'h3c;
  localparam logic [7:0] PBPM_BCTRL_OFS = 8'h3e;
  localparam logic [7:0] PBPM_CAP_LIST_DW_OFS = 8'h7c;
  localparam logic [7:0] PBPM_CAP_LIST_OFS = 8'h7f;
  localparam logic [7:0] PBPM_PMCAP_OFS = 8'h80;
  // Bridge control field positions.
  localparam int PBPM_BC_ISA_BIT = 2;
  localparam int PBPM_BC_SERR_BIT = 1;
  localparam int PBPM_BC_PERR_BIT = 0;
  localparam int PBPM_BC_DW_SHIFT = 16;
  localparam int PBPM_CAP_LIST_DW_SHIFT = 24;
  localparam logic PBPM_ISA_RESET = 1'b0;
  localparam logic PBPM_SERR_RESET = 1'b0;
  localparam logic PBPM_PERR_VALUE = 1'b0;
  localparam logic PBPM_MSIH_RESET = 1'b0;
  // Power-management capability fields.
  localparam logic [4:0] PBPM_PME_SUPPORT = 5'h19;
  localparam logic [1:0] PBPM_D2D1_SUPPORT = 2'h0;
  localparam logic [2:0] PBPM_AUX_CURRENT = 3'h0;
  localparam logic PBPM_DSI = 1'b0;
  localparam logic PBPM_AUX_POWER_SOURCE = 1'b0;
  localparam logic PBPM_WAKE_CLOCK = 1'b0;
  localparam logic [2:0] PBPM_PM_VERSION = 3'h2;
  localparam logic [7:0] PBPM_NEXT_MSI = 8'h90;
  localparam logic [7:0] PBPM_NEXT_PCIE = 8'ha0;
  localparam logic [7:0] PBPM_PM_CAP_ID = 8'h01;
  localparam logic [31:0] PBPM_PMCAP_RESET = 32'hc8029001;
  // ISA aliases: bits 9:8 of an I/O address nonzero means upper 768 bytes of a 1-KB block.
  localparam int PBPM_ISA_HI = 9;
  localparam int PBPM_ISA_LO = 8;
  // Error message type codes.
  typedef enum logic [1:0] {
    PBPM_ERR_COR,
    PBPM_ERR_NONFATAL,
    PBPM_ERR_FATAL
  } pbpm_err_t;
endpackage : pbpm_pkg

// file: rtl/pbpm_ctrl_if.sv
`timescale 1ns/1ps
interface pbpm_ctrl_if;
  logic isa_exclude;
  logic serr_forward;
  logic parity_response;
  modport ctrl (output isa_exclude, output serr_forward, output parity_response);
  modport fwd (input isa_exclude, input serr_forward, input parity_response);
endinterface : pbpm_ctrl_if

// file: rtl/pbpm_forward.sv
`timescale 1ns/1ps
module pbpm_forward
  import pbpm_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control bits from the register bank.
  pbpm_ctrl_if.fwd ctrl,
  // Processor I/O cycles.
  input wire logic io_valid_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [15:0] io_window_base_i,
  input wire logic [15:0] io_window_limit_i,
  output logic io_to_pcie_o,
  output logic io_to_hub_o,
  // Error messages from the link.
  input wire logic err_valid_i,
  input wire pbpm_err_t err_type_i,
  input wire logic [2:0] root_err_enable_i,
  output logic serr_msg_o,
  // Poisoned completions.
  input wire logic poisoned_cpl_i,
  output logic parity_status_set_o
);

  function automatic logic in_window(input logic [15:0] a, input logic [15:0] b,
                                     input logic [15:0] l);
    in_window = (a >= b) && (a <= l);
  endfunction : in_window

  function automatic logic isa_alias(input logic [15:0] a);
    isa_alias = |a[PBPM_ISA_HI:PBPM_ISA_LO];
  endfunction : isa_alias

  logic io_to_pcie_q;
  logic io_to_hub_q;
  logic serr_msg_q;
  logic parity_status_set_q;
  logic io_to_pcie_d;
  logic io_to_hub_d;
  logic serr_msg_d;
  logic parity_status_set_d;
  logic hit;
  logic excl;

  always_comb begin
    hit = io_valid_i && in_window(io_addr_i, io_window_base_i, io_window_limit_i);
    excl = ctrl.isa_exclude && isa_alias(io_addr_i);
    io_to_pcie_d = hit && !excl;
    io_to_hub_d = hit && excl;
    serr_msg_d = err_valid_i && ctrl.serr_forward && root_err_enable_i[err_type_i];
    parity_status_set_d = poisoned_cpl_i && ctrl.parity_response;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_to_pcie_q <= 1'b0;
      io_to_hub_q <= 1'b0;
      serr_msg_q <= 1'b0;
      parity_status_set_q <= 1'b0;
    end else begin
      io_to_pcie_q <= io_to_pcie_d;
      io_to_hub_q <= io_to_hub_d;
      serr_msg_q <= serr_msg_d;
      parity_status_set_q <= parity_status_set_d;
    end
  end

  assign io_to_pcie_o = io_to_pcie_q;
  assign io_to_hub_o = io_to_hub_q;
  assign serr_msg_o = serr_msg_q;
  assign parity_status_set_o = parity_status_set_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  a_io_pcie_route: assert property (
    io_valid_i && !ctrl.isa_exclude && in_window(io_addr_i, io_window_base_i, io_window_limit_i)
    |=> io_to_pcie_q && !io_to_hub_q)
    else $error("In-window I/O not routed to the link.");

  a_isa_hub_route: assert property (
    io_valid_i && ctrl.isa_exclude && isa_alias(io_addr_i)
    && in_window(io_addr_i, io_window_base_i, io_window_limit_i)
    |=> io_to_hub_q && !io_to_pcie_q)
    else $error("ISA alias not sent to the hub link.");

  a_out_window_idle: assert property (
    !(io_valid_i && in_window(io_addr_i, io_window_base_i, io_window_limit_i))
    |=> !io_to_hub_q && !io_to_pcie_q)
    else $error("Out-of-window I/O was routed.");

  a_serr_blocked: assert property (
    !ctrl.serr_forward |=> !serr_msg_q)
    else $error("System error raised while forwarding disabled.");

  a_serr_forwarded: assert property (
    err_valid_i && ctrl.serr_forward |=> serr_msg_q == $past(root_err_enable_i[err_type_i]))
    else $error("System error does not follow root enables.");

  a_parity_never: assert property (
    poisoned_cpl_i |=> !parity_status_set_q)
    else $error("Parity status set by poisoned completion.");

  a_serr_needs_msg: assert property (
    !err_valid_i |=> !serr_msg_q)
    else $error("System error raised with no error message.");

endmodule : pbpm_forward

// file: rtl/pbpm_config.sv
`timescale 1ns/1ps
module pbpm_config
  import pbpm_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Configuration access port.
  input wire logic cfg_valid_i,
  input wire logic cfg_write_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_byte_en_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // Processor I/O routing.
  input wire logic io_valid_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [15:0] io_window_base_i,
  input wire logic [15:0] io_window_limit_i,
  output logic io_to_pcie_o,
  output logic io_to_hub_o,
  // Error messages from the link.
  input wire logic err_valid_i,
  input wire pbpm_err_t err_type_i,
  input wire logic [2:0] root_err_enable_i,
  output logic serr_msg_o,
  // Poisoned read completions.
  input wire logic poisoned_cpl_i,
  output logic parity_status_set_o
);

  pbpm_ctrl_if ctrl_if ();

  logic isa_range_exclude_enable_q;
  logic isa_range_exclude_enable_d;
  logic system_error_forward_enable_q;
  logic system_error_forward_enable_d;
  logic msi_capability_hide_q;
  logic msi_capability_hide_d;
  logic cfg_ack_q;
  logic cfg_ack_d;
  logic [31:0] cfg_rdata_q;
  logic [31:0] cfg_rdata_d;
  logic [15:0] bctrl_val;
  logic [31:0] pmcap_val;
  logic wr;

  // The capability word is built from constants and the MSI hide bit, so no write to its own offset can reach it.
  function automatic logic [31:0] pm_cap_word(input logic hide);
    pm_cap_word = {PBPM_PME_SUPPORT,
                   PBPM_D2D1_SUPPORT,
                   PBPM_AUX_CURRENT,
                   PBPM_DSI, PBPM_AUX_POWER_SOURCE,
                   PBPM_WAKE_CLOCK,
                   PBPM_PM_VERSION,
                   hide ? PBPM_NEXT_PCIE : PBPM_NEXT_MSI,
                   PBPM_PM_CAP_ID};
  endfunction : pm_cap_word

  always_comb begin
    wr = cfg_valid_i && cfg_write_i;
    bctrl_val = 16'h0000;
    bctrl_val[PBPM_BC_ISA_BIT] = isa_range_exclude_enable_q;
    bctrl_val[PBPM_BC_SERR_BIT] = system_error_forward_enable_q;
    bctrl_val[PBPM_BC_PERR_BIT] = PBPM_PERR_VALUE;
    pmcap_val = pm_cap_word(msi_capability_hide_q);
    isa_range_exclude_enable_d = isa_range_exclude_enable_q;
    system_error_forward_enable_d = system_error_forward_enable_q;
    msi_capability_hide_d = msi_capability_hide_q;
    // Only the writable bits are loaded; bit 0 and the capability word ignore writes.
    if (wr && cfg_addr_i[7:2] == PBPM_BCTRL_DW_OFS[7:2] && cfg_byte_en_i[2]) begin
      isa_range_exclude_enable_d = cfg_wdata_i[PBPM_BC_DW_SHIFT + PBPM_BC_ISA_BIT];
      system_error_forward_enable_d = cfg_wdata_i[PBPM_BC_DW_SHIFT + PBPM_BC_SERR_BIT];
    end
    if (wr && cfg_addr_i[7:2] == PBPM_CAP_LIST_DW_OFS[7:2] && cfg_byte_en_i[3]) begin
      msi_capability_hide_d = cfg_wdata_i[PBPM_CAP_LIST_DW_SHIFT];
    end
    cfg_ack_d = cfg_valid_i;
    cfg_rdata_d = 32'h00000000;
    if (cfg_valid_i && !cfg_write_i) begin
      unique case (cfg_addr_i[7:2])
        PBPM_BCTRL_DW_OFS[7:2]: cfg_rdata_d = {bctrl_val, 16'h0000};
        PBPM_CAP_LIST_DW_OFS[7:2]: cfg_rdata_d = {7'h00, msi_capability_hide_q, 24'h000000};
        PBPM_PMCAP_OFS[7:2]: cfg_rdata_d = pmcap_val;
        default: cfg_rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      isa_range_exclude_enable_q <= PBPM_ISA_RESET;
      system_error_forward_enable_q <= PBPM_SERR_RESET;
      msi_capability_hide_q <= PBPM_MSIH_RESET;
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= 32'h00000000;
    end else begin
      isa_range_exclude_enable_q <= isa_range_exclude_enable_d;
      system_error_forward_enable_q <= system_error_forward_enable_d;
      msi_capability_hide_q <= msi_capability_hide_d;
      cfg_ack_q <= cfg_ack_d;
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  assign cfg_ack_o = cfg_ack_q;
  assign cfg_rdata_o = cfg_rdata_q;
  assign ctrl_if.isa_exclude = isa_range_exclude_enable_q;
  assign ctrl_if.serr_forward = system_error_forward_enable_q;
  assign ctrl_if.parity_response = PBPM_PERR_VALUE;

  pbpm_forward u_forward (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ctrl(ctrl_if.fwd),
    .io_valid_i(io_valid_i),
    .io_addr_i(io_addr_i),
    .io_window_base_i(io_window_base_i),
    .io_window_limit_i(io_window_limit_i),
    .io_to_pcie_o(io_to_pcie_o),
    .io_to_hub_o(io_to_hub_o),
    .err_valid_i(err_valid_i),
    .err_type_i(err_type_i),
    .root_err_enable_i(root_err_enable_i),
    .serr_msg_o(serr_msg_o),
    .poisoned_cpl_i(poisoned_cpl_i),
    .parity_status_set_o(parity_status_set_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_pm_read;
    cfg_valid_i && !cfg_write_i && cfg_addr_i[7:2] == PBPM_PMCAP_OFS[7:2];
  endsequence

  a_pm_fixed_fields: assert property (
    s_pm_read |=> cfg_ack_o && cfg_rdata_o[31:16] == 16'hc802)
    else $error("Capability upper fields wrong.");

  a_pm_next_ptr: assert property (
    s_pm_read |=> cfg_rdata_o[15:8] == ($past(msi_capability_hide_q) ? 8'ha0 : 8'h90))
    else $error("Next capability pointer wrong.");

  a_pm_cap_id: assert property (
    s_pm_read |=> cfg_rdata_o[7:0] == 8'h01 && cfg_rdata_o[25:19] == 7'h00)
    else $error("Capability ID or hardwired zeros wrong.");

  a_pm_version: assert property (
    s_pm_read |=> cfg_rdata_o[18:16] == 3'h2)
    else $error("Capability version wrong.");

  a_ro_write_kept: assert property (
    cfg_valid_i && cfg_write_i && cfg_addr_i[7:2] == PBPM_PMCAP_OFS[7:2]
    |=> cfg_ack_o ##0 $stable(msi_capability_hide_q))
    else $error("Read-only write disturbed state.");

  a_bctrl_perr_zero: assert property (
    cfg_valid_i && !cfg_write_i && cfg_addr_i[7:2] == PBPM_BCTRL_DW_OFS[7:2]
    |=> cfg_rdata_o[16] == 1'b0 && cfg_rdata_o[18] == $past(isa_range_exclude_enable_q))
    else $error("Bridge control readback wrong.");

  sequence s_bctrl_write;
    cfg_valid_i && cfg_write_i && cfg_addr_i[7:2] == PBPM_BCTRL_DW_OFS[7:2]
    && cfg_byte_en_i[2];
  endsequence

  sequence s_cap_list_write;
    cfg_valid_i && cfg_write_i && cfg_addr_i[7:2] == PBPM_CAP_LIST_DW_OFS[7:2]
    && cfg_byte_en_i[3];
  endsequence

  a_ack_every_access: assert property (
    cfg_valid_i |=> cfg_ack_o)
    else $error("Configuration access not acknowledged.");

  a_idle_bus_quiet: assert property (
    !cfg_valid_i |=> !cfg_ack_o && cfg_rdata_o == 32'h00000000)
    else $error("Acknowledge or read data outlived its cycle.");

  a_write_data_zero: assert property (
    cfg_valid_i && cfg_write_i |=> cfg_rdata_o == 32'h00000000)
    else $error("Write returned read data.");

  a_bctrl_write_load: assert property (
    s_bctrl_write |=>
      isa_range_exclude_enable_q == $past(cfg_wdata_i[PBPM_BC_DW_SHIFT + PBPM_BC_ISA_BIT]) &&
      system_error_forward_enable_q == $past(cfg_wdata_i[PBPM_BC_DW_SHIFT + PBPM_BC_SERR_BIT]))
    else $error("Bridge control write not loaded.");

  a_bctrl_held: assert property (
    !(cfg_valid_i && cfg_write_i && cfg_addr_i[7:2] == PBPM_BCTRL_DW_OFS[7:2]
      && cfg_byte_en_i[2])
    |=> $stable(isa_range_exclude_enable_q) && $stable(system_error_forward_enable_q))
    else $error("Bridge control changed without a write.");

  a_hide_write_load: assert property (
    s_cap_list_write |=> msi_capability_hide_q == $past(cfg_wdata_i[PBPM_CAP_LIST_DW_SHIFT]))
    else $error("Capability hide bit not loaded.");

  a_hide_readback: assert property (
    cfg_valid_i && !cfg_write_i && cfg_addr_i[7:2] == PBPM_CAP_LIST_DW_OFS[7:2]
    |=> cfg_rdata_o == {7'h00, $past(msi_capability_hide_q), 24'h000000})
    else $error("Capability hide readback wrong.");

  a_unmapped_zero: assert property (
    cfg_valid_i && !cfg_write_i && cfg_addr_i[7:2] != PBPM_BCTRL_DW_OFS[7:2]
    && cfg_addr_i[7:2] != PBPM_CAP_LIST_DW_OFS[7:2]
    && cfg_addr_i[7:2] != PBPM_PMCAP_OFS[7:2]
    |=> cfg_rdata_o == 32'h00000000)
    else $error("Unmapped read returned data.");

endmodule : pbpm_config

// file: dv/pbpm_link_model.sv
`timescale 1ns/1ps
module pbpm_link_model
  import pbpm_pkg::*;
(
  // Clock.
  input wire logic clock_i,
  // Messages towards the port.
  output logic err_valid_o,
  output pbpm_err_t err_type_o,
  output logic poisoned_o
);
  initial begin
    err_valid_o = 1'b0;
    err_type_o = PBPM_ERR_COR;
    poisoned_o = 1'b0;
  end

  // After a message the type moves on, so a stale value can never look valid.
  task automatic send_err(input pbpm_err_t t);
    @(posedge clock_i);
    err_valid_o <= 1'b1;
    err_type_o <= t;
    @(posedge clock_i);
    err_valid_o <= 1'b0;
    err_type_o <= (t == PBPM_ERR_FATAL) ? PBPM_ERR_COR : pbpm_err_t'(t + 2'h1);
  endtask : send_err

  task automatic send_poison();
    @(posedge clock_i);
    poisoned_o <= 1'b1;
    @(posedge clock_i);
    poisoned_o <= 1'b0;
  endtask : send_poison
endmodule : pbpm_link_model

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  import pbpm_pkg::*;
  logic clock_i = 1'b0, reset_n_i = 1'b0;
  logic cfg_valid_i = 1'b0, cfg_write_i = 1'b0, cfg_ack_o;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_byte_en_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, rd;
  logic io_valid_i = 1'b0, io_to_pcie_o, io_to_hub_o;
  logic [15:0] io_addr_i = 16'h0, io_window_base_i = 16'h1000, io_window_limit_i = 16'h1fff;
  logic err_valid_i, poisoned_cpl_i, serr_msg_o, parity_status_set_o;
  pbpm_err_t err_type_i;
  logic [2:0] root_err_enable_i = 3'h7;
  int errors = 0, n_checks = 0;

  always #2 clock_i = ~clock_i;

  pbpm_config i_pbpm_config (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .cfg_valid_i(cfg_valid_i), .cfg_write_i(cfg_write_i), .cfg_addr_i(cfg_addr_i),
    .cfg_byte_en_i(cfg_byte_en_i), .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o),
    .cfg_rdata_o(cfg_rdata_o), .io_valid_i(io_valid_i), .io_addr_i(io_addr_i),
    .io_window_base_i(io_window_base_i), .io_window_limit_i(io_window_limit_i),
    .io_to_pcie_o(io_to_pcie_o), .io_to_hub_o(io_to_hub_o), .err_valid_i(err_valid_i),
    .err_type_i(err_type_i), .root_err_enable_i(root_err_enable_i),
    .serr_msg_o(serr_msg_o), .poisoned_cpl_i(poisoned_cpl_i),
    .parity_status_set_o(parity_status_set_o));

  pbpm_link_model i_pbpm_link_model (.clock_i(clock_i), .err_valid_o(err_valid_i),
    .err_type_o(err_type_i), .poisoned_o(poisoned_cpl_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  function automatic logic [31:0] exp_cap(input logic hide);
    return {PBPM_PME_SUPPORT, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0, 3'h2, hide ? 8'ha0 : 8'h90, 8'h01};
  endfunction : exp_cap

  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    @(posedge clock_i);
    cfg_valid_i <= 1'b1;
    cfg_write_i <= wr;
    cfg_addr_i <= a;
    cfg_byte_en_i <= be;
    cfg_wdata_i <= wd;
    @(posedge clock_i);
    cfg_valid_i <= 1'b0;
    cfg_wdata_i <= ~wd;
    #1;
    check({31'h0, cfg_ack_o}, 32'h1, "ack");
    rd = cfg_rdata_o;
  endtask : cfg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'hf, 32'h0);
    check(rd, exp, "read");
  endtask : rd_chk

  task automatic io_chk(input logic [15:0] a, input logic p, input logic h);
    @(posedge clock_i);
    io_valid_i <= 1'b1;
    io_addr_i <= a;
    @(posedge clock_i);
    io_valid_i <= 1'b0;
    io_addr_i <= ~a;
    #1;
    check({30'h0, io_to_pcie_o, io_to_hub_o}, {30'h0, p, h}, "route");
  endtask : io_chk

  task automatic t_regs();
    rd_chk(8'h80, exp_cap(1'b0));
    rd_chk(8'h3c, 32'h0);
    cfg(1'b1, 8'h80, 4'hf, 32'hffffffff);
    rd_chk(8'h40, 32'h0);
    rd_chk(8'h80, exp_cap(1'b0));
    cfg(1'b1, 8'h3c, 4'h4, 32'h0001_0000);
    rd_chk(8'h3c, 32'h0);
    cfg(1'b1, 8'h7c, 4'h8, 32'h0100_0000);
    rd_chk(8'h7c, 32'h0100_0000);
    rd_chk(8'h80, exp_cap(1'b1));
    cfg(1'b1, 8'h7c, 4'h8, 32'h0);
    rd_chk(8'h80, exp_cap(1'b0));
  endtask : t_regs

  task automatic t_io();
    io_chk(16'h1300, 1'b1, 1'b0);
    io_chk(16'h1fff, 1'b1, 1'b0);
    io_chk(16'h2000, 1'b0, 1'b0);
    cfg(1'b1, 8'h3c, 4'h4, 32'h0004_0000);
    rd_chk(8'h3c, 32'h0004_0000);
    io_chk(16'h1100, 1'b0, 1'b1);
    io_chk(16'h13ff, 1'b0, 1'b1);
    io_chk(16'h1000, 1'b1, 1'b0);
    cfg(1'b1, 8'h3c, 4'hb, 32'h0);
    io_chk(16'h1100, 1'b0, 1'b1);
    io_chk(16'h0300, 1'b0, 1'b0);
    io_chk(16'h2100, 1'b0, 1'b0);
    @(posedge clock_i);
    io_window_base_i <= 16'h0400;
    io_window_limit_i <= 16'h07ff;
    io_chk(16'h0400, 1'b1, 1'b0);
    io_chk(16'h03ff, 1'b0, 1'b0);
    io_chk(16'h0500, 1'b0, 1'b1);
  endtask : t_io

  // Each type is tried with only its own enable and with every other one.
  task automatic t_err();
    for (int f = 0; f < 2; f++) begin
      cfg(1'b1, 8'h3c, 4'h4, f ? 32'h0002_0000 : 32'h0);
      for (int t = 0; t < 6; t++) begin
        @(posedge clock_i);
        root_err_enable_i <= (t < 3) ? 3'h1 << t : ~(3'h1 << (t - 3));
        i_pbpm_link_model.send_err(pbpm_err_t'(t % 3));
        #1;
        check({31'h0, serr_msg_o}, {31'h0, f == 1 && t < 3}, "serr");
      end
    end
    i_pbpm_link_model.send_poison();
    #1;
    check({31'h0, parity_status_set_o}, 32'h0, "parity");
  endtask : t_err

  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("MISMATCH %0t timeout", $time);
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_io();
    t_err();
    tally_and_finish();
  end
endmodule : tb
